/* File: oesb_bank.sv */
// Object entry status bank: device kind word and fault summary register.
`timescale 1ns/1ps

module oesb_bank #(
  parameter bit STEPPER_KIND = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Fault conditions from the drive, asynchronous to this clock
  input wire logic general_fault_i,
  input wire logic amperage_fault_i,
  input wire logic supply_level_fault_i,
  input wire logic thermal_fault_i,
  input wire logic link_fault_i,
  input wire logic behaviour_fault_i,
  input wire logic wrong_rotation_i,
  // Entry access request
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [15:0] req_index_i,
  input wire logic [7:0] req_subindex_i,
  input wire logic [31:0] req_wdata_i,
  // Entry access answer
  output logic ans_valid_o,
  output logic [1:0] ans_code_o,
  output logic [31:0] ans_rdata_o,
  // Live fault summary
  output logic [7:0] fault_summary_o
);

  // ----------------------------------------------------------------------
  // Fault input synchronisers
  // ----------------------------------------------------------------------
  logic [7:0] fault_raw;
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] fault_summary_r;
  logic [31:0] device_kind_word_r;

  // Bit six has no source, so it is tied low before the synchroniser.
  assign fault_raw = {wrong_rotation_i, 1'b0, behaviour_fault_i,
                      link_fault_i, thermal_fault_i, supply_level_fault_i,
                      amperage_fault_i, general_fault_i};

  // Two stages guard against metastability on the drive's fault lines.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end else begin
      sync1_r <= fault_raw;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------------
  // Fault summary register
  // ----------------------------------------------------------------------
  // The summary mirrors conditions; there is no sticky state to clear.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_summary_r <= oesb_pkg::OESB_FAULT_RESET;
    end else begin
      fault_summary_r <= sync2_r;
      fault_summary_r[oesb_pkg::OESB_BIT_UNUSED] <= 1'b0;
      fault_summary_r[oesb_pkg::OESB_BIT_ROTATION] <=
        sync2_r[oesb_pkg::OESB_BIT_ROTATION];
    end
  end

  assign fault_summary_o = fault_summary_r;

  // ----------------------------------------------------------------------
  // Device kind word
  // ----------------------------------------------------------------------
  // Loaded on the first edge after reset release, since an asynchronous
  // reset may only take a constant.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      device_kind_word_r <= oesb_pkg::OESB_KIND_RESET;
    end else begin
      device_kind_word_r <= 32'h0000_0000;
      device_kind_word_r[oesb_pkg::OESB_KIND_MSB:oesb_pkg::OESB_KIND_LSB] <=
        STEPPER_KIND ? oesb_pkg::OESB_KIND_STEPPER
                     : oesb_pkg::OESB_KIND_SERVO;
      device_kind_word_r[oesb_pkg::OESB_DRIVE_BEHAVIOUR_FAULT_FLAG_MSB:0] <=
        oesb_pkg::OESB_PROFILE_NUM;
    end
  end

  // ----------------------------------------------------------------------
  // Entry access
  // ----------------------------------------------------------------------
  // Both entries are single variables with no subentries, so no array or
  // text count exists; every other subindex is answered as absent.
  function automatic logic [1:0] oesb_decode(input logic [15:0] idx,
                                              input logic [7:0] sub);
    if ((idx == oesb_pkg::OESB_IDX_KIND || idx == oesb_pkg::OESB_IDX_FAULT)
        && sub == oesb_pkg::OESB_SUB_ZERO) begin
      oesb_decode = oesb_pkg::OESB_ANS_OK;
    end else begin
      oesb_decode = oesb_pkg::OESB_ANS_NO_ENTRY;
    end
  endfunction : oesb_decode

  logic ans_valid_r;
  logic [1:0] ans_code_r;
  logic [31:0] ans_rdata_r;
  logic [1:0] dec;

  assign dec = oesb_decode(req_index_i, req_subindex_i);

  // One-cycle answer; writes never change a read-only entry, and with no
  // writable entry the allowed-value list is never exercised.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ans_valid_r <= 1'b0;
      ans_code_r <= oesb_pkg::OESB_ANS_OK;
      ans_rdata_r <= 32'h0000_0000;
    end else begin
      ans_valid_r <= req_valid_i;
      ans_rdata_r <= 32'h0000_0000;
      if (!req_valid_i) begin
        ans_code_r <= oesb_pkg::OESB_ANS_OK;
      end else if (dec != oesb_pkg::OESB_ANS_OK) begin
        ans_code_r <= dec;
      end else if (req_write_i) begin
        ans_code_r <= oesb_pkg::OESB_ANS_READ_ONLY;
      end else begin
        ans_code_r <= oesb_pkg::OESB_ANS_OK;
        if (req_index_i == oesb_pkg::OESB_IDX_KIND) begin
          ans_rdata_r <= device_kind_word_r;
        end else begin
          ans_rdata_r <= {24'h000000, fault_summary_r};
        end
      end
    end
  end

  assign ans_valid_o = ans_valid_r;
  assign ans_code_o = ans_code_r;
  assign ans_rdata_o = ans_rdata_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // The general fault held for three samples must show two samples later:
  // two synchroniser stages and then the summary register itself.
  sequence s_fault_held;
    general_fault_i ##1 general_fault_i ##1 general_fault_i;
  endsequence

  sequence s_fault_seen;
    ##2 fault_summary_r[oesb_pkg::OESB_BIT_GENERAL];
  endsequence

  // Every driven bit follows its synchronised condition both ways; a
  // sticky bit would pass the first check but trip the second.
  for (genvar b = 0; b < 8; b++) begin : g_bit_chk
    if (b != oesb_pkg::OESB_BIT_UNUSED) begin : g_live
      AST_FAULT_SET: assert property (@(posedge clk_i)
        disable iff (!resetn_i) sync2_r[b] |=> fault_summary_r[b])
        else $error("fault bit did not set");
      AST_FAULT_CLEAR: assert property (@(posedge clk_i)
        disable iff (!resetn_i) !sync2_r[b] |=> !fault_summary_r[b])
        else $error("fault bit did not clear");
    end
  end

  AST_UNUSED_ZERO: assert property (@(posedge clk_i)
    disable iff (!resetn_i) !fault_summary_o[oesb_pkg::OESB_BIT_UNUSED])
    else $error("unused bit set");
  AST_ROTATION: assert property (@(posedge clk_i)
    disable iff (!resetn_i) $rose(sync2_r[oesb_pkg::OESB_BIT_ROTATION])
    |=> fault_summary_o[oesb_pkg::OESB_BIT_ROTATION])
    else $error("rotation flag missing");
  AST_KIND: assert property (@(posedge clk_i)
    disable iff (!resetn_i) $past(resetn_i) |->
    device_kind_word_r[oesb_pkg::OESB_KIND_MSB:oesb_pkg::OESB_KIND_LSB] ==
    (STEPPER_KIND ? oesb_pkg::OESB_KIND_STEPPER : oesb_pkg::OESB_KIND_SERVO))
    else $error("motor kind wrong");
  AST_PROFILE: assert property (@(posedge clk_i)
    disable iff (!resetn_i) $past(resetn_i) |->
    device_kind_word_r[oesb_pkg::OESB_DRIVE_BEHAVIOUR_FAULT_FLAG_MSB:0] ==
    oesb_pkg::OESB_PROFILE_NUM)
    else $error("profile number wrong");
  AST_RO_REFUSE: assert property (@(posedge clk_i)
    disable iff (!resetn_i) req_valid_i && req_write_i &&
    dec == oesb_pkg::OESB_ANS_OK
    |=> ans_code_o == oesb_pkg::OESB_ANS_READ_ONLY)
    else $error("read-only write not refused");
  AST_RO_NO_DATA: assert property (@(posedge clk_i)
    disable iff (!resetn_i) req_valid_i && req_write_i
    |=> ans_valid_o && ans_rdata_o == 32'h0000_0000)
    else $error("refused write returned data");
  AST_SUB_NONZERO: assert property (@(posedge clk_i)
    disable iff (!resetn_i) req_valid_i &&
    req_subindex_i != oesb_pkg::OESB_SUB_ZERO
    |=> ans_code_o == oesb_pkg::OESB_ANS_NO_ENTRY)
    else $error("nonzero subindex accepted");
  // A summary read returns the value held at the request edge, so a host
  // never sees a copy older than one cycle.
  AST_READ_LIVE: assert property (@(posedge clk_i)
    disable iff (!resetn_i) req_valid_i && !req_write_i &&
    dec == oesb_pkg::OESB_ANS_OK && req_index_i == oesb_pkg::OESB_IDX_FAULT
    |=> ans_rdata_o == {24'h000000, $past(fault_summary_r)})
    else $error("summary read stale");
  AST_TRACK: assert property (@(posedge clk_i)
    disable iff (!resetn_i) s_fault_held |-> s_fault_seen)
    else $error("summary lagged fault");

endmodule : oesb_bank

/* File: oesb_pkg.sv */
// Package with entry offsets, field layouts and preset values of the bank.
package oesb_pkg;

  // ----------------------------------------------------------------------
  // Entry indices and subindices
  // ----------------------------------------------------------------------
  localparam logic [15:0] OESB_IDX_KIND = 16'h1000;
  localparam logic [15:0] OESB_IDX_FAULT = 16'h1001;
  localparam logic [7:0] OESB_SUB_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // Device kind word layout and values
  // ----------------------------------------------------------------------
  localparam int OESB_KIND_MSB = 23;
  localparam int OESB_KIND_LSB = 16;
  localparam int OESB_DRIVE_BEHAVIOUR_FAULT_FLAG_MSB = 15;
  localparam logic [7:0] OESB_KIND_SERVO = 8'h01;
  localparam logic [7:0] OESB_KIND_STEPPER = 8'h02;
  localparam logic [15:0] OESB_PROFILE_NUM = 16'h0192;
  localparam logic [31:0] OESB_KIND_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Fault summary layout and preset
  // ----------------------------------------------------------------------
  localparam int OESB_BIT_GENERAL = 0;
  localparam int OESB_BIT_AMPERAGE = 1;
  localparam int OESB_BIT_SUPPLY = 2;
  localparam int OESB_BIT_THERMAL = 3;
  localparam int OESB_BIT_LINK = 4;
  localparam int OESB_BIT_BEHAVIOUR = 5;
  localparam int OESB_BIT_UNUSED = 6;
  localparam int OESB_BIT_ROTATION = 7;
  localparam logic [7:0] OESB_FAULT_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Access answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] OESB_ANS_OK = 2'h0;
  localparam logic [1:0] OESB_ANS_READ_ONLY = 2'h1;
  localparam logic [1:0] OESB_ANS_NO_ENTRY = 2'h2;

endpackage : oesb_pkg

/* File: oesb_host_model.sv */
// Host model that issues entry requests to the status bank.
`timescale 1ns/1ps
module oesb_host_model (
  // Clock
  input wire logic clk_i,
  // Request to the bank
  output logic req_valid_o,
  output logic req_write_o,
  output logic [15:0] req_index_o,
  output logic [7:0] req_subindex_o,
  output logic [31:0] req_wdata_o,
  // Answer from the bank
  input wire logic ans_valid_i,
  input wire logic [1:0] ans_code_i,
  input wire logic [31:0] ans_rdata_i
);
  // -----------------------------------------------------------------
  // One request per call, driven on the falling edge.
  // -----------------------------------------------------------------
  initial begin
    req_valid_o = 1'b0;
    req_write_o = 1'b0;
    req_index_o = 16'h0000;
    req_subindex_o = 8'h00;
    req_wdata_o = 32'h0000_0000;
  end

  // Idle lines show the inverse of the last request, never a stale copy.
  task automatic access(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, output logic seen, output logic [1:0] code,
      output logic [31:0] data);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    req_write_o = wr;
    req_index_o = idx;
    req_subindex_o = sub;
    req_wdata_o = 32'ha5a5_5a5a;
    @(negedge clk_i);
    // The answer stands only in the cycle after the request edge, so it
    // is taken here, before the request is released.
    seen = ans_valid_i;
    code = ans_code_i;
    data = ans_rdata_i;
    req_valid_o = 1'b0;
    req_write_o = ~wr;
    req_index_o = ~idx;
    req_subindex_o = ~sub;
    req_wdata_o = 32'h5a5a_a5a5;
  endtask : access
endmodule : oesb_host_model

/* File: test_object_entry_status_bank.sv */
// Self-checking bench for the object entry status bank.
`timescale 1ns/1ps
module test_object_entry_status_bank;
  logic clk;
  logic resetn;
  logic [6:0] flt;
  logic [7:0] e;
  logic rv, rw, av;
  logic [15:0] ri;
  logic [7:0] rs, fs;
  logic [31:0] wd, ad;
  logic [1:0] ac;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  // Kind word expected with the default stepper setting of the bank.
  localparam logic [31:0] exp_kind = {8'h00, oesb_pkg::OESB_KIND_STEPPER,
    oesb_pkg::OESB_PROFILE_NUM};

  // -----------------------------------------------------------------
  // Design, host model, clock and cycle ceiling.
  // -----------------------------------------------------------------
  oesb_bank dut (.clk_i(clk), .resetn_i(resetn),
    .general_fault_i(flt[0]), .amperage_fault_i(flt[1]),
    .supply_level_fault_i(flt[2]), .thermal_fault_i(flt[3]),
    .link_fault_i(flt[4]), .behaviour_fault_i(flt[5]),
    .wrong_rotation_i(flt[6]), .req_valid_i(rv), .req_write_i(rw),
    .req_index_i(ri), .req_subindex_i(rs), .req_wdata_i(wd),
    .ans_valid_o(av), .ans_code_o(ac), .ans_rdata_o(ad),
    .fault_summary_o(fs));
  oesb_host_model host (.clk_i(clk), .req_valid_o(rv), .req_write_o(rw),
    .req_index_o(ri), .req_subindex_o(rs), .req_wdata_o(wd),
    .ans_valid_i(av), .ans_code_i(ac), .ans_rdata_i(ad));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // The whole run needs well under a thousand cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] x,
      input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // One entry access, checking strobe, answer code and read data.
  task automatic op(input logic wr, input logic [15:0] idx,
      input logic [7:0] sub, input logic [1:0] xc, input logic [31:0] xd);
    logic s;
    logic [1:0] c;
    logic [31:0] d;
    host.access(wr, idx, sub, s, c, d);
    chk("ans_valid", 32'h1, {31'h0, s});
    chk("ans_code", {30'h0, xc}, {30'h0, c});
    chk("ans_rdata", xd, d);
  endtask : op

  // -----------------------------------------------------------------
  // Main sequence.
  // -----------------------------------------------------------------
  initial begin
    flt = 7'h00;
    resetn = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    chk("summary", 32'h0, {24'h0, fs});
    op(1'b0, oesb_pkg::OESB_IDX_FAULT, 8'h00, 2'h0, 32'h0);
    op(1'b0, oesb_pkg::OESB_IDX_KIND, 8'h00, 2'h0, exp_kind);
    // Each input alone, then all together; bit six must stay low.
    for (int i = 0; i < 8; i++) begin
      flt = (i == 7) ? 7'h7f : 7'h01 << i;
      e = {flt[6], 1'b0, flt[5:0]};
      repeat (2) @(negedge clk);
      chk("summary_early", 32'h0, {24'h0, fs});
      @(negedge clk);
      chk("summary", {24'h0, e}, {24'h0, fs});
      op(1'b0, oesb_pkg::OESB_IDX_FAULT, 8'h00, 2'h0, {24'h0, e});
      flt = 7'h00;
      repeat (3) @(negedge clk);
      chk("summary_clear", 32'h0, {24'h0, fs});
    end
    op(1'b1, oesb_pkg::OESB_IDX_KIND, 8'h00, 2'h1, 32'h0);
    op(1'b1, oesb_pkg::OESB_IDX_FAULT, 8'h00, 2'h1, 32'h0);
    op(1'b0, oesb_pkg::OESB_IDX_KIND, 8'h00, 2'h0, exp_kind);
    op(1'b0, 16'h1002, 8'h00, 2'h2, 32'h0);
    op(1'b0, oesb_pkg::OESB_IDX_KIND, 8'h01, 2'h2, 32'h0);
    // Reset in mid-run with every fault present; presets must return.
    flt = 7'h7f;
    repeat (4) @(negedge clk);
    chk("summary_all", 32'h0000_00bf, {24'h0, fs});
    resetn = 1'b0;
    @(negedge clk);
    chk("summary_reset", 32'h0, {24'h0, fs});
    flt = 7'h00;
    repeat (15) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    chk("summary_after", 32'h0, {24'h0, fs});
    op(1'b0, oesb_pkg::OESB_IDX_KIND, 8'h00, 2'h0, exp_kind);
    report_and_stop();
  end
endmodule : test_object_entry_status_bank
